//--- core/rtcsr_pkg.sv
package rtcsr_pkg;
   // ==========================================
   // Bus addressing and register map
   localparam logic [6:0] DEV_ADDR = 7'h68;
   localparam int N_REGS = 16;
   localparam logic [3:0] REG_HUND = 4'h0;
   localparam logic [3:0] REG_SEC = 4'h1;
   localparam logic [3:0] REG_MIN = 4'h2;
   localparam logic [3:0] REG_HOUR = 4'h3;
   localparam logic [3:0] REG_WDAY = 4'h4;
   localparam logic [3:0] REG_DATE = 4'h5;
   localparam logic [3:0] REG_CMON = 4'h6;
   localparam logic [3:0] REG_YEAR = 4'h7;
   localparam logic [3:0] REG_FLAGS = 4'hF;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   // ==========================================
   // Field positions
   localparam int HALT_BIT = 7;
   localparam int OSC_FAIL_IRQ_ENABLE_BIT = 7;
   localparam int OF_BIT = 2;
   localparam int CB_LSB = 6;
   localparam int TIME_SEL_BIT = 3;
   // ==========================================
   // BCD field masks and limits
   localparam logic [7:0] M_HUND = 8'hFF;
   localparam logic [7:0] M_SEC = 8'h7F;
   localparam logic [7:0] M_HOUR = 8'h3F;
   localparam logic [7:0] M_WDAY = 8'h07;
   localparam logic [7:0] M_DATE = 8'h3F;
   localparam logic [7:0] M_MON = 8'h1F;
   localparam logic [7:0] MAX_HUND = 8'h99;
   localparam logic [7:0] MAX_SEC = 8'h59;
   localparam logic [7:0] MAX_HOUR = 8'h23;
   localparam logic [7:0] MAX_WDAY = 8'h07;
   localparam logic [7:0] MAX_MON = 8'h12;
   localparam logic [7:0] BCD_ZERO = 8'h00;
   localparam logic [7:0] BCD_ONE = 8'h01;
   // ==========================================
   // Timing
   localparam int OSC_HZ = 32768;
   localparam int HUND_PER_S = 100;
   localparam int CORE_MHZ = 200;
   localparam int OSC_FAIL_NS = 122070;
   localparam int FAIL_CYC_DEF = OSC_FAIL_NS * CORE_MHZ / 1000;
   localparam int FCNT_W = 20;
   // ==========================================
   // Types
   typedef enum logic [2:0] {S_IDLE, S_DEV, S_PTR, S_WR, S_RD} rtcsr_state_t;
   typedef struct packed {
      logic bit_val;
      logic tog;
   } rtcsr_link_t;
   typedef struct packed {
      logic [2:0] scl_v;
      logic [2:0] sda_v;
      logic [2:0] osc_v;
      logic [2:0] tog_v;
      rtcsr_state_t st;
      logic busy;
      logic rw;
      logic ack;
      logic dirty;
      logic sda_oe;
      logic sda_o;
      logic irq_n;
      logic [3:0] cnt;
      logic [3:0] ptr;
      logic [7:0] sh;
      logic [7:0] tx;
      logic [N_REGS-1:0][7:0] regs;
      logic [7:0][7:0] tcnt;
      logic [15:0] acc;
      logic [FCNT_W-1:0] fcnt;
   } rtcsr_core_t;
endpackage

//--- core/rtcsr_top.sv
// What this block does
// R1: SDA falling while SCL high starts a transfer.
// R2: Only address byte matching the fixed bus address is acknowledged.
// R3: SDA rising while SCL high ends the transfer.
// R4: SDA stable while SCL high; one clock pulse per bit.
// R5: Transfers bracketed by start/stop, bytes of eight plus acknowledge bit.
// R6: Acknowledger holds SDA low through the acknowledge clock high phase.
// R7: Master leaves last read byte unacknowledged; device releases SDA.
// R8: Addressed read: pointer write, repeated start, read address, data out.
// R9: Pointer advances only on acknowledge clock; next byte follows.
// R10: Sequential reads continue until a stop.
// R11: Snapshot updates halt while pointer is in time range; resume otherwise.
// R12: Read without pointer write starts at the last pointer value.
// R13: Write: address, word address, data; each acked, pointer advances.
// R14: Time kept in BCD from a 32.768 kHz oscillator.
// R15: Any time write zeroes sub-seconds; sub-seconds accept only zero.
// R16: Weekday in low three bits; then date, month, year registers.
// R17: Halt bit in seconds stops the oscillator; clearing restarts it.
// R18: Software should pulse the halt bit after first power-up.
// R19: Fail interrupt enable makes oscillator fail drive the interrupt output.
// R20: Century bits sit in top two bits of century/month register.
// R21: Any time-range write reloads time and resets the divider chain.
// R22: Buffers track counters when idle; freeze at access start.
// R23: Bits sampled on SCL rise; eighth bit moves byte into register.
// R24: Buffered time loads counters at pointer reaching 8 or stop.
// R25: Four-bit pointer wraps from the last register to zero.
`timescale 1ns/10ps
`default_nettype none
module rtcsr_top #(
   parameter int FAIL_CYC = rtcsr_pkg::FAIL_CYC_DEF
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic i_osc_32k,
   output logic o_sda_o,
   output logic o_sda_oe,
   output logic o_irq_n
);
   // ==========================================
   // Link domain: sample SDA on every SCL rise
   rtcsr_pkg::rtcsr_link_t l;
   rtcsr_pkg::rtcsr_link_t next_l;

   // R23: rising edge sample
   always_comb begin
      next_l = l;
      next_l.bit_val = i_sda;
      next_l.tog = ~l.tog;
   end

   // Link registers
   always_ff @(posedge i_scl or negedge i_rst_n) begin
      if (!i_rst_n) begin
         l <= '0;
      end else begin
         l <= next_l;
      end
   end

   // ==========================================
   // Core domain
   rtcsr_pkg::rtcsr_core_t s;
   rtcsr_pkg::rtcsr_core_t next_s;
   logic start_ev, stop_ev, bit_ev, scl_fall, osc_ok, byte_done, ack_clk;
   logic load, wr, track, hund_tick, fail_ev;
   logic [7:0] rx_byte;
   logic [16:0] acc_sum;

   // Days in a month, with leap years from the BCD year
   function automatic logic [7:0] dim(input logic [7:0] mon, input logic [7:0] yr);
      logic leap;
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
             (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      case (mon & rtcsr_pkg::M_MON)
         8'h02: dim = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: dim = 8'h30;
         default: dim = 8'h31;
      endcase
   endfunction

   // BCD step of a masked field; top bit of result is the carry
   function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] m,
      input logic [7:0] mx, input logic [7:0] mn);
      logic [7:0] f;
      logic [7:0] r;
      f = v & m;
      if (f >= mx) begin
         r = mn;
      end else if (f[3:0] == 4'h9) begin
         r = {f[7:4] + 4'h1, 4'h0};
      end else begin
         r = f + 8'h01;
      end
      bcd_step = {f >= mx, (v & ~m) | (r & m)};
   endfunction

   // R1: start detection on synchronised pins
   assign start_ev = s.scl_v[1] & s.scl_v[2] & s.sda_v[2] & ~s.sda_v[1];
   // R3: stop detection
   assign stop_ev = s.scl_v[1] & s.scl_v[2] & ~s.sda_v[2] & s.sda_v[1];
   // R4: one event per SCL pulse
   assign bit_ev = s.tog_v[1] ^ s.tog_v[2];
   assign scl_fall = s.scl_v[2] & ~s.scl_v[1];
   assign rx_byte = {s.sh[6:0], l.bit_val};
   assign byte_done = bit_ev & (s.st != rtcsr_pkg::S_IDLE) & (s.cnt == rtcsr_pkg::BIT_LAST);
   assign ack_clk = bit_ev & (s.st != rtcsr_pkg::S_IDLE) & (s.cnt == rtcsr_pkg::ACK_SLOT);
   // R23: eighth bit stores the byte
   assign wr = byte_done & (s.st == rtcsr_pkg::S_WR);
   // R24: deferred load on stop or pointer reaching the non-time range
   assign load = s.dirty & (stop_ev | (ack_clk & (s.st != rtcsr_pkg::S_DEV) &
                 (s.ptr == rtcsr_pkg::REG_YEAR)));
   // R22: track when idle; R11: resume once pointer leaves time range
   assign track = (~s.busy | s.ptr[rtcsr_pkg::TIME_SEL_BIT]) & ~load;
   // R17: halt bit stops the oscillator
   assign osc_ok = s.osc_v[1] & ~s.osc_v[2] & ~s.tcnt[rtcsr_pkg::REG_SEC][rtcsr_pkg::HALT_BIT];
   // R14: exact 1/100 s from the 32.768 kHz edges
   assign acc_sum = {1'b0, s.acc} + 17'(rtcsr_pkg::HUND_PER_S);
   assign hund_tick = osc_ok & (acc_sum >= 17'(rtcsr_pkg::OSC_HZ));
   assign fail_ev = ~osc_ok & (s.fcnt == rtcsr_pkg::FCNT_W'(FAIL_CYC - 1));

   // Next state of the core
   always_comb begin
      logic c;
      logic [8:0] r;
      c = 1'b0;
      r = '0;
      next_s = s;
      next_s.scl_v = {s.scl_v[1:0], i_scl};
      next_s.sda_v = {s.sda_v[1:0], i_sda};
      next_s.osc_v = {s.osc_v[1:0], i_osc_32k};
      next_s.tog_v = {s.tog_v[1:0], l.tog};
      next_s.sda_o = 1'b0;
      // R22: buffers copy counters while not frozen
      if (track) begin
         for (int i = 0; i < 8; i++) begin
            next_s.regs[i] = s.tcnt[i];
         end
      end
      // R5: byte framing
      if (start_ev) begin
         next_s.st = rtcsr_pkg::S_DEV;
         next_s.cnt = '0;
         next_s.busy = 1'b1;
         next_s.ack = 1'b0;
         next_s.sda_oe = 1'b0;
      end else if (stop_ev) begin
         next_s.st = rtcsr_pkg::S_IDLE;
         next_s.busy = 1'b0;
         next_s.sda_oe = 1'b0;
      end else if (bit_ev && s.st != rtcsr_pkg::S_IDLE) begin
         if (s.cnt != rtcsr_pkg::ACK_SLOT) begin
            next_s.sh = rx_byte;
            next_s.cnt = s.cnt + 4'h1;
         end else begin
            next_s.cnt = '0;
            next_s.ack = 1'b0;
         end
         if (byte_done) begin
            case (s.st)
               rtcsr_pkg::S_DEV: begin
                  // R2: answer only the fixed address
                  next_s.ack = (rx_byte[7:1] == rtcsr_pkg::DEV_ADDR);
                  next_s.rw = rx_byte[0];
                  // R12: read starts at the current pointer
                  next_s.tx = s.regs[s.ptr];
                  if (rx_byte[7:1] != rtcsr_pkg::DEV_ADDR) begin
                     next_s.st = rtcsr_pkg::S_IDLE;
                  end
               end
               rtcsr_pkg::S_PTR: begin
                  // R8: word address loads the pointer
                  next_s.ptr = rx_byte[3:0];
                  next_s.ack = 1'b1;
               end
               rtcsr_pkg::S_WR: begin
                  // R13: data byte acknowledged
                  next_s.ack = 1'b1;
               end
               default: begin
                  next_s.ack = 1'b0;
               end
            endcase
         end
         if (ack_clk) begin
            case (s.st)
               rtcsr_pkg::S_DEV: begin
                  next_s.st = s.rw ? rtcsr_pkg::S_RD : rtcsr_pkg::S_PTR;
               end
               rtcsr_pkg::S_PTR: begin
                  next_s.st = rtcsr_pkg::S_WR;
               end
               rtcsr_pkg::S_WR: begin
                  // R9: advance on acknowledge clock; R25: wraps at four bits
                  next_s.ptr = s.ptr + 4'h1;
               end
               rtcsr_pkg::S_RD: begin
                  // R10: acknowledged byte fetches the next register
                  if (!l.bit_val) begin
                     next_s.ptr = s.ptr + 4'h1;
                     next_s.tx = s.regs[s.ptr + 4'h1];
                  end else begin
                     // R7: not acknowledged, stop driving
                     next_s.st = rtcsr_pkg::S_IDLE;
                  end
               end
               default: begin
                  next_s.st = rtcsr_pkg::S_IDLE;
               end
            endcase
         end
      end else if (scl_fall) begin
         // R6: hold SDA low through the acknowledge clock
         if (s.st != rtcsr_pkg::S_IDLE && s.cnt == rtcsr_pkg::ACK_SLOT) begin
            next_s.sda_oe = s.ack;
         end else if (s.st == rtcsr_pkg::S_RD) begin
            next_s.sda_oe = ~s.tx[3'(rtcsr_pkg::BIT_LAST - s.cnt)];
         end else begin
            next_s.sda_oe = 1'b0;
         end
      end
      // R23: write the assembled byte into the pointed register
      if (wr) begin
         next_s.regs[s.ptr] = rx_byte;
         if (!s.ptr[rtcsr_pkg::TIME_SEL_BIT]) begin
            // R15: sub-seconds only ever take zero
            next_s.regs[rtcsr_pkg::REG_HUND] = rtcsr_pkg::BCD_ZERO;
            next_s.dirty = 1'b1;
         end
         if (s.ptr == rtcsr_pkg::REG_FLAGS) begin
            next_s.regs[s.ptr][rtcsr_pkg::OF_BIT] = rx_byte[rtcsr_pkg::OF_BIT] &
               s.regs[s.ptr][rtcsr_pkg::OF_BIT];
         end
      end
      // Oscillator watchdog; a new failure wins over a clear
      next_s.fcnt = osc_ok ? '0 : (fail_ev ? s.fcnt : s.fcnt + 1'b1);
      if (fail_ev) begin
         next_s.regs[rtcsr_pkg::REG_FLAGS][rtcsr_pkg::OF_BIT] = 1'b1;
      end
      // R19: fail interrupt gated by the enable bit
      next_s.irq_n = ~(s.regs[rtcsr_pkg::REG_FLAGS][rtcsr_pkg::OF_BIT] &
         s.tcnt[rtcsr_pkg::REG_MIN][rtcsr_pkg::OSC_FAIL_IRQ_ENABLE_BIT]);
      // R14: divider and BCD counter chain
      if (osc_ok) begin
         next_s.acc = hund_tick ? 16'(acc_sum - 17'(rtcsr_pkg::OSC_HZ)) : acc_sum[15:0];
      end
      c = hund_tick;
      if (c) begin
         r = bcd_step(s.tcnt[0], rtcsr_pkg::M_HUND, rtcsr_pkg::MAX_HUND, rtcsr_pkg::BCD_ZERO);
         next_s.tcnt[0] = r[7:0];
         c = r[8];
      end
      for (int i = 1; i < 3; i++) begin
         if (c) begin
            r = bcd_step(s.tcnt[i], rtcsr_pkg::M_SEC, rtcsr_pkg::MAX_SEC, rtcsr_pkg::BCD_ZERO);
            next_s.tcnt[i] = r[7:0];
            c = r[8];
         end
      end
      if (c) begin
         r = bcd_step(s.tcnt[3], rtcsr_pkg::M_HOUR, rtcsr_pkg::MAX_HOUR, rtcsr_pkg::BCD_ZERO);
         next_s.tcnt[3] = r[7:0];
         c = r[8];
      end
      if (c) begin
         // R16: weekday in the low three bits, then date, month, year
         r = bcd_step(s.tcnt[4], rtcsr_pkg::M_WDAY, rtcsr_pkg::MAX_WDAY, rtcsr_pkg::BCD_ONE);
         next_s.tcnt[4] = r[7:0];
         r = bcd_step(s.tcnt[5], rtcsr_pkg::M_DATE, dim(s.tcnt[6], s.tcnt[7]), rtcsr_pkg::BCD_ONE);
         next_s.tcnt[5] = r[7:0];
         c = r[8];
      end
      if (c) begin
         r = bcd_step(s.tcnt[6], rtcsr_pkg::M_MON, rtcsr_pkg::MAX_MON, rtcsr_pkg::BCD_ONE);
         next_s.tcnt[6] = r[7:0];
         c = r[8];
      end
      if (c) begin
         r = bcd_step(s.tcnt[7], rtcsr_pkg::M_HUND, rtcsr_pkg::MAX_HUND, rtcsr_pkg::BCD_ZERO);
         next_s.tcnt[7] = r[7:0];
         c = r[8];
      end
      if (c) begin
         // R20: century bits count in the top two bits
         next_s.tcnt[6][7:rtcsr_pkg::CB_LSB] = s.tcnt[6][7:rtcsr_pkg::CB_LSB] + 2'h1;
      end
      // R21: any time-range write reloads counters and clears the divider
      if (load) begin
         for (int i = 0; i < 8; i++) begin
            next_s.tcnt[i] = s.regs[i];
         end
         next_s.tcnt[0] = rtcsr_pkg::BCD_ZERO;
         next_s.acc = '0;
         next_s.dirty = 1'b0;
      end
   end

   // Core registers
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s <= '0;
         // SCL and SDA samplers start at the idle-high bus level, so no false start or stop follows reset
         s.scl_v <= '1;
         s.sda_v <= '1;
         s.irq_n <= 1'b1;
         s.st <= rtcsr_pkg::S_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign o_sda_o = s.sda_o;
   assign o_sda_oe = s.sda_oe;
   assign o_irq_n = s.irq_n;

   // ==========================================
   // Assertions
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   // R1: start opens an access
   start_busy_a: assert property (start_ev |=> s.busy && s.st == rtcsr_pkg::S_DEV && s.cnt == 4'h0) // R1
      else $error("start did not open an access");
   // R2: foreign address is not answered
   addr_miss_a: assert property (byte_done && s.st == rtcsr_pkg::S_DEV &&
      rx_byte[7:1] != rtcsr_pkg::DEV_ADDR |=> s.st == rtcsr_pkg::S_IDLE && !s.ack) // R2
      else $error("foreign address was acknowledged");
   // R3: stop closes the access
   stop_idle_a: assert property (stop_ev |=> !s.busy && s.st == rtcsr_pkg::S_IDLE) // R3
      else $error("stop did not close the access");
   // R6: acknowledge drives SDA low
   ack_drive_a: assert property (scl_fall && s.cnt == rtcsr_pkg::ACK_SLOT && s.ack &&
      s.st != rtcsr_pkg::S_IDLE && !start_ev && !stop_ev && !bit_ev |=> o_sda_oe) // R6
      else $error("acknowledge not driven");
   // R7: not acknowledged read releases the bus
   nack_rel_a: assert property (ack_clk && s.st == rtcsr_pkg::S_RD && l.bit_val &&
      !start_ev && !stop_ev |=> s.st == rtcsr_pkg::S_IDLE && !o_sda_oe ##1 !o_sda_oe [*8]) // R7
      else $error("bus not released after last byte");
   // R9: pointer steps by one on a data acknowledge
   ptr_step_a: assert property (ack_clk && s.st == rtcsr_pkg::S_WR && !start_ev && !stop_ev
      |=> s.ptr == $past(s.ptr) + 4'h1) // R9
      else $error("pointer did not advance");
   // R15: sub-seconds read zero after a time write
   hund_zero_a: assert property (wr && !s.ptr[rtcsr_pkg::TIME_SEL_BIT]
      |=> s.regs[rtcsr_pkg::REG_HUND] == rtcsr_pkg::BCD_ZERO && s.dirty) // R15
      else $error("sub-seconds not cleared");
   // R17: halted oscillator freezes the counters
   halt_hold_a: assert property (s.tcnt[rtcsr_pkg::REG_SEC][rtcsr_pkg::HALT_BIT] && !load
      |=> $stable(s.tcnt[rtcsr_pkg::REG_HUND]) && $stable(s.acc)) // R17
      else $error("counters ran while halted");
   // R19: enabled fail flag drives the interrupt
   irq_fail_a: assert property (s.regs[rtcsr_pkg::REG_FLAGS][rtcsr_pkg::OF_BIT] &&
      s.tcnt[rtcsr_pkg::REG_MIN][rtcsr_pkg::OSC_FAIL_IRQ_ENABLE_BIT] |=> !o_irq_n) // R19
      else $error("interrupt not raised");
   // R22: frozen buffers hold during an access in the time range
   freeze_a: assert property (s.busy && !s.ptr[rtcsr_pkg::TIME_SEL_BIT] && !wr
      |=> $stable(s.regs[rtcsr_pkg::REG_SEC])) // R22
      else $error("snapshot changed during access");
   // R24: load copies buffers and restarts the divider
   load_copy_a: assert property (load |=> !s.dirty && s.acc == 16'h0000 &&
      s.tcnt[rtcsr_pkg::REG_YEAR] == $past(s.regs[rtcsr_pkg::REG_YEAR])) // R24
      else $error("buffered time not loaded");

   cov_write_c: cover property (wr ##[1:200] load);
   cov_read_c: cover property (ack_clk && s.st == rtcsr_pkg::S_RD && !l.bit_val);
   cov_alt_c: cover property (start_ev ##[1:200] (ack_clk && s.st == rtcsr_pkg::S_DEV && s.rw));
   cov_fail_c: cover property (fail_ev);
endmodule
`default_nettype wire

//--- tb/rtcsr_master_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Two-wire bus master: SCL stands high between frames, SDA released to pull-up
module rtcsr_master_model (
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_oe
);
   // Bus idle: both lines released
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
   end

   task automatic bit_out(input logic b);
      o_sda_oe = !b;
      #16 o_scl = 1'b1;
      #32 o_scl = 1'b0;
      #16;
   endtask

   task automatic bit_in(output logic b);
      o_sda_oe = 1'b0;
      #16 o_scl = 1'b1;
      #16 b = i_sda;
      #16 o_scl = 1'b0;
      #16;
   endtask

   task automatic start();
      o_sda_oe = 1'b0;
      #16 o_scl = 1'b1;
      #32 o_sda_oe = 1'b1;
      #32 o_scl = 1'b0;
      #16;
   endtask

   task automatic stop();
      o_sda_oe = 1'b1;
      #16 o_scl = 1'b1;
      #32 o_sda_oe = 1'b0;
      #32;
   endtask

   // byte MSB first, then ack slot
   task automatic wbyte(input logic [7:0] v, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_out(v[i]);
      end
      bit_in(ack);
   endtask

   // ack each byte, leave last one unacknowledged
   task automatic rbyte(output logic [7:0] v, input logic nack);
      for (int i = 7; i >= 0; i--) begin
         bit_in(v[i]);
      end
      bit_out(nack);
   endtask
endmodule
`default_nettype wire

//--- tb/rtcsr_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module rtcsr_tb_top;
   typedef struct packed {
      logic [3:0] a;
      logic [7:0] w;
      logic [7:0] e;
   } rtcsr_row_t;
   logic clk, rst_n, osc, scl, m_oe, sda_oe, sda_o, irq_n, sda, ak;
   logic [7:0] v;
   int n_mismatch, checks, cyc;
   // Address, written value, value read back
   rtcsr_row_t rows [11] = '{'{4'h0, 8'h55, 8'h00}, '{4'h3, 8'h23, 8'h23}, '{4'h4, 8'h03, 8'h03},
      '{4'h5, 8'h15, 8'h15}, '{4'h6, 8'hC5, 8'hC5}, '{4'h7, 8'h99, 8'h99}, '{4'h2, 8'h12, 8'h12},
      '{4'h1, 8'h30, 8'h30}, '{4'h9, 8'hA5, 8'hA5}, '{4'hC, 8'h77, 8'h77}, '{4'hE, 8'h5A, 8'h5A}};

   // ==========================================
   // Open-drain wire with pull-up
   assign sda = !(sda_oe | m_oe);

   rtcsr_top #(.FAIL_CYC(64)) i_rtcsr_top (.i_core_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
      .i_osc_32k(osc), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_irq_n(irq_n));
   rtcsr_master_model i_rtcsr_master_model (.i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));

   // ==========================================
   // Core clock and shortened oscillator
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      osc = 1'b0;
      #1.3;
      forever #100 osc = ~osc;
   end

   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         print_verdict();
      end
   end

   // ==========================================
   // Shared tasks
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Pointer load then data bytes
   task automatic wr(input logic [3:0] a, input logic [7:0] d[$]);
      i_rtcsr_master_model.start();
      i_rtcsr_master_model.wbyte(8'hD0, ak);
      check({7'h00, ak}, 8'h00);
      i_rtcsr_master_model.wbyte({4'h0, a}, ak);
      check({7'h00, ak}, 8'h00);
      foreach (d[i]) begin
         i_rtcsr_master_model.wbyte(d[i], ak);
         check({7'h00, ak}, 8'h00);
      end
      i_rtcsr_master_model.stop();
   endtask

   // Read, with or without pointer load first
   task automatic rd(input logic [3:0] a, input logic addressed, input logic [7:0] e[$]);
      i_rtcsr_master_model.start();
      if (addressed) begin
         i_rtcsr_master_model.wbyte(8'hD0, ak);
         i_rtcsr_master_model.wbyte({4'h0, a}, ak);
         i_rtcsr_master_model.start();
      end
      i_rtcsr_master_model.wbyte(8'hD1, ak);
      check({7'h00, ak}, 8'h00);
      foreach (e[i]) begin
         i_rtcsr_master_model.rbyte(v, i == e.size() - 1);
         check(v, e[i]);
      end
      i_rtcsr_master_model.stop();
   endtask

   // ==========================================
   // Main sequence
   initial begin
      rst_n = 1'b0;
      n_mismatch = 0;
      checks = 0;
      cyc = 0;
      repeat (8) @(posedge clk);
      check({7'h00, sda_oe}, 8'h00);
      check({7'h00, irq_n}, 8'h01);
      repeat (8) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (10) @(posedge clk);
      // Foreign address is not acknowledged, rest of frame ignored
      i_rtcsr_master_model.start();
      i_rtcsr_master_model.wbyte(8'hA0, ak);
      check({7'h00, ak}, 8'h01);
      i_rtcsr_master_model.wbyte(8'h00, ak);
      check({7'h00, ak}, 8'h01);
      i_rtcsr_master_model.stop();
      // Table of single writes and read-backs
      foreach (rows[i]) begin
         wr(rows[i].a, '{rows[i].w});
         rd(rows[i].a, 1'b1, '{rows[i].e});
      end
      // Two-byte write leaves pointer at 0x0C; read without pointer load
      wr(4'hA, '{8'h33, 8'h44});
      rd(4'h0, 1'b0, '{8'h77});
      rd(4'hA, 1'b1, '{8'h33, 8'h44, 8'h77});
      // Halt the clock with fail interrupt enabled
      wr(4'h1, '{8'h80, 8'h92});
      repeat (120) @(posedge clk);
      check({7'h00, irq_n}, 8'h00);
      // Wrap 0x0F to 0x00 with frozen time and fail flag set
      rd(4'hE, 1'b1, '{8'h5A, 8'h04, 8'h00, 8'h80, 8'h92});
      // release halt, then clear the fail flag
      wr(4'h1, '{8'h00});
      wr(4'hF, '{8'h00});
      repeat (20) @(posedge clk);
      check({7'h00, irq_n}, 8'h01);
      check({7'h00, sda_oe}, 8'h00);
      check({7'h00, sda_o}, 8'h00);
      print_verdict();
   end
endmodule
`default_nettype wire
